// ===== common/dfp_regs.svh
// register offsets, reset values, field positions and timing for the fan drive block
`ifndef DFP_REGS_SVH
`define DFP_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DFP_ADDR_MAIN_CONFIG 8'h20
`define DFP_ADDR_ALERT_ALLOW 8'h29
`define DFP_ADDR_INVERT 8'h2A
`define DFP_ADDR_DRIVE_TYPE 8'h2B
`define DFP_ADDR_BASE_FREQ 8'h2D
`define DFP_ADDR_DRIVE1 8'h30
`define DFP_ADDR_DIVIDER1 8'h31
`define DFP_ADDR_CONTROL1 8'h32
`define DFP_ADDR_DRIVE2 8'h40
`define DFP_ADDR_DIVIDER2 8'h41
`define DFP_ADDR_CONTROL2 8'h42

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DFP_RST_MAIN_CONFIG 8'h40
`define DFP_RST_ZERO 8'h00
`define DFP_RST_DIVIDER 8'h01
`define DFP_RST_CONTROL 8'h2B

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DFP_ALERT_BLOCK_BIT 7
`define DFP_CLOSED_LOOP_BIT 7
`define DFP_SCALE_HI 6
`define DFP_SCALE_LO 5
`define DFP_EDGES_HI 4
`define DFP_EDGES_LO 3
`define DFP_INTERVAL_HI 2
`define DFP_INTERVAL_LO 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DFP_CLK_PERIOD_NS 5
`define DFP_CLK_HZ 200000000
`define DFP_BASE_F0_HZ 26000
`define DFP_BASE_F1_HZ 19531
`define DFP_BASE_F2_HZ 4882
`define DFP_BASE_F3_HZ 2441
`define DFP_PWM_STEPS 255
`define DFP_UPDATE_UNIT_MS 100
`define DFP_UPDATE_UNIT_CYC ((`DFP_UPDATE_UNIT_MS * 1000000) / `DFP_CLK_PERIOD_NS)

`endif

// ===== common/dfp_pkg.sv
// types shared by the fan drive block
package dfp_pkg;

    typedef enum logic [3:0] {
        DFP_BUS_IDLE = 4'h0,
        DFP_BUS_ADDR = 4'h1,
        DFP_BUS_ADDR_ACK = 4'h3,
        DFP_BUS_CMD = 4'h2,
        DFP_BUS_CMD_ACK = 4'h6,
        DFP_BUS_WDATA = 4'h7,
        DFP_BUS_WDATA_ACK = 4'h5,
        DFP_BUS_RDATA = 4'h4,
        DFP_BUS_RDATA_ACK = 4'hC
    } dfp_bus_st_t;

    typedef struct packed {
        logic scl;
        logic sda;
        dfp_bus_st_t st;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic host_ack;
        logic sda_oe_b;
        logic [7:0] main_cfg;
        logic [1:0] allow;
        logic [1:0] invert;
        logic [1:0] push_pull;
        logic [3:0] base_sel;
        logic [1:0][7:0] drive;
        logic [1:0][7:0] divider;
        logic [1:0][7:0] control;
        logic alert_b;
    } dfp_top_t;

    typedef struct packed {
        logic [8:0] pre;
        logic [7:0] dcnt;
        logic [7:0] step;
        logic pin;
        logic oe_b;
    } dfp_pwm_t;

    typedef struct packed {
        logic [24:0] unit_cnt;
        logic [4:0] units;
        logic tick;
    } dfp_tick_t;

endpackage

// ===== rtl/dfp_pwm_chan.sv
// one pwm output channel: base prescaler, divider, duty compare and pin driver
`timescale 1ns/1ps
`include "dfp_regs.svh"
module dfp_pwm_chan
    import dfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] value_i,
    input wire logic [7:0] div_i,
    input wire logic [1:0] base_sel_i,
    input wire logic invert_i,
    input wire logic push_pull_i,
    output logic pin_o,
    output logic pin_oe_b_o
);

    localparam logic [8:0] PRE0 = 9'(`DFP_CLK_HZ / (`DFP_BASE_F0_HZ * `DFP_PWM_STEPS) - 1);
    localparam logic [8:0] PRE1 = 9'(`DFP_CLK_HZ / (`DFP_BASE_F1_HZ * `DFP_PWM_STEPS) - 1);
    localparam logic [8:0] PRE2 = 9'(`DFP_CLK_HZ / (`DFP_BASE_F2_HZ * `DFP_PWM_STEPS) - 1);
    localparam logic [8:0] PRE3 = 9'(`DFP_CLK_HZ / (`DFP_BASE_F3_HZ * `DFP_PWM_STEPS) - 1);
    localparam logic [7:0] LAST_STEP = 8'(`DFP_PWM_STEPS - 1);

    dfp_pwm_t q, d;
    logic [8:0] pre_lim;
    logic [7:0] div_eff;
    logic level;

    always_comb begin
        d = q;
        // R06 R07 base frequency decode
        case (base_sel_i)
            2'h0: pre_lim = PRE0;
            2'h1: pre_lim = PRE1;
            2'h2: pre_lim = PRE2;
            default: pre_lim = PRE3;
        endcase
        // R09 zero divider acts as one
        div_eff = (div_i == 8'h00) ? 8'h01 : div_i;
        // R08 divider stretches every step
        if (q.pre >= pre_lim) begin
            d.pre = 9'h000;
            if (q.dcnt >= div_eff - 8'h01) begin
                d.dcnt = 8'h00;
                d.step = (q.step >= LAST_STEP) ? 8'h00 : q.step + 8'h01;
            end else begin
                d.dcnt = q.dcnt + 8'h01;
            end
        end else begin
            d.pre = q.pre + 9'h001;
        end
        // R12 R03 R04 duty compare and polarity
        level = (q.step < value_i) ^ invert_i;
        // R05 open drain releases when high
        if (push_pull_i) begin
            d.pin = level;
            d.oe_b = 1'b0;
        end else begin
            d.pin = 1'b0;
            d.oe_b = level;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '{pre: 9'h000, dcnt: 8'h00, step: 8'h00, pin: 1'b0, oe_b: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign pin_o = q.pin;
    assign pin_oe_b_o = q.oe_b;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    full_duty_a: assert property ( // R03
        (value_i == 8'hFF && !invert_i && push_pull_i) [*2] |-> pin_o)
        else $error("ff drive did not hold output high");
    inv_zero_a: assert property ( // R04
        (value_i == 8'h00 && invert_i && push_pull_i) [*2] |-> pin_o)
        else $error("inverted zero drive did not hold output high");
    drive_type_a: assert property ( // R05
        !push_pull_i |=> pin_o == 1'b0)
        else $error("open drain output drove high");

endmodule // dfp_pwm_chan

// ===== rtl/dfp_update_tick.sv
// update interval timer: one pulse per selected interval
`timescale 1ns/1ps
`include "dfp_regs.svh"
module dfp_update_tick
    import dfp_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = `DFP_UPDATE_UNIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);

    dfp_tick_t q, d;
    logic [4:0] units_lim;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        // R16 interval in 100 ms units
        case (sel_i)
            3'h0: units_lim = 5'h01;
            3'h1: units_lim = 5'h02;
            3'h2: units_lim = 5'h03;
            3'h3: units_lim = 5'h04;
            3'h4: units_lim = 5'h05;
            3'h5: units_lim = 5'h08;
            3'h6: units_lim = 5'h0C;
            default: units_lim = 5'h10;
        endcase
        if (q.unit_cnt >= 25'(UNIT_CYCLES - 1)) begin
            d.unit_cnt = 25'h0000000;
            if (q.units + 5'h01 >= units_lim) begin
                d.units = 5'h00;
                d.tick = 1'b1;
            end else begin
                d.units = q.units + 5'h01;
            end
        end else begin
            d.unit_cnt = q.unit_cnt + 25'h0000001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '{unit_cnt: 25'h0000000, units: 5'h00, tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    tick_single_a: assert property ( // R16
        tick_o |=> !tick_o)
        else $error("update tick lasted more than one cycle");

endmodule // dfp_update_tick

// ===== rtl/dfp_fan_drive.sv
// dual fan pwm drive: serial register slave, alert gating, closed-loop stepping
//
// Functional notes
// (R01) allowed channel error asserts alert
// (R02) disallowed channel error keeps alert quiet
// (R03) normal polarity: 00h is 0%, FFh 100%
// (R04) inverted polarity: 00h is 100%, FFh 0%
// (R05) output type bit: open drain or push-pull
// (R06) base select fields per channel in one register
// (R07) base select picks one of four frequencies
// (R08) final frequency is base over divider
// (R09) divider zero behaves as one
// (R10) drive readback returns applied value
// (R11) closed loop discards drive writes
// (R12) duty equals value over 255
// (R13) control bit 7 selects closed loop
// (R14) scale field multiplies tach target
// (R15) edges field selects edges per turn
// (R16) interval field sets update period
// (R17) one step per update interval
// (R18) host rescales target for pole mismatch
// (R19) global block bit silences alert
// (R20) reset restores register defaults
`timescale 1ns/1ps
`include "dfp_regs.svh"
module dfp_fan_drive
    import dfp_pkg::*;
#(
    parameter logic [6:0] BUS_ADDR = 7'h10,
    parameter int unsigned UPDATE_UNIT_CYCLES = `DFP_UPDATE_UNIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic smb_clk_i,
    input wire logic smb_data_i,
    output logic smb_data_o,
    output logic smb_data_oe_b_o,
    output logic alert_b_o,
    input wire logic [1:0] fan_error_i,
    input wire logic [7:0] fan_step_i,
    input wire logic [1:0][15:0] tach_count_i,
    input wire logic [1:0][15:0] tach_target_i,
    output logic [1:0] pwm_o,
    output logic [1:0] pwm_oe_b_o,
    output logic [1:0][1:0] tach_edges_o
);

    dfp_top_t q, d;
    logic [1:0] tick;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0] rd_data;
    logic [1:0] drive_wr;
    logic [8:0] sum;
    logic [18:0] tgt_eff;

    // ----------------------------------------------------------------
    // per-channel pwm and update timers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            dfp_pwm_chan u_pwm (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .value_i(q.drive[g]),
                .div_i(q.divider[g]),
                .base_sel_i(q.base_sel[2*g+1 -: 2]),
                .invert_i(q.invert[g]),
                .push_pull_i(q.push_pull[g]),
                .pin_o(pwm_o[g]),
                .pin_oe_b_o(pwm_oe_b_o[g])
            );
            dfp_update_tick #(
                .UNIT_CYCLES(UPDATE_UNIT_CYCLES)
            ) u_tick (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .sel_i(q.control[g][`DFP_INTERVAL_HI:`DFP_INTERVAL_LO]),
                .tick_o(tick[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // register readback
    // ----------------------------------------------------------------
    always_comb begin
        case (q.ptr)
            `DFP_ADDR_MAIN_CONFIG: rd_data = q.main_cfg;
            `DFP_ADDR_ALERT_ALLOW: rd_data = {6'h00, q.allow};
            `DFP_ADDR_INVERT: rd_data = {6'h00, q.invert};
            `DFP_ADDR_DRIVE_TYPE: rd_data = {6'h00, q.push_pull};
            `DFP_ADDR_BASE_FREQ: rd_data = {4'h0, q.base_sel};
            // R10 applied drive is what reads back
            `DFP_ADDR_DRIVE1: rd_data = q.drive[0];
            `DFP_ADDR_DIVIDER1: rd_data = q.divider[0];
            `DFP_ADDR_CONTROL1: rd_data = q.control[0];
            `DFP_ADDR_DRIVE2: rd_data = q.drive[1];
            `DFP_ADDR_DIVIDER2: rd_data = q.divider[1];
            `DFP_ADDR_CONTROL2: rd_data = q.control[1];
            default: rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        drive_wr = 2'b00;
        sum = 9'h000;
        tgt_eff = 19'h00000;
        d.scl = smb_clk_i;
        d.sda = smb_data_i;
        scl_rise = smb_clk_i && !q.scl;
        scl_fall = !smb_clk_i && q.scl;
        bus_start = smb_clk_i && q.scl && q.sda && !smb_data_i;
        bus_stop = smb_clk_i && q.scl && !q.sda && smb_data_i;

        case (q.st)
            DFP_BUS_IDLE: begin
                d.sda_oe_b = 1'b1;
            end
            DFP_BUS_ADDR, DFP_BUS_CMD, DFP_BUS_WDATA: begin
                if (scl_rise && q.bcnt < 4'h8) begin
                    d.sh = {q.sh[6:0], smb_data_i};
                    d.bcnt = q.bcnt + 4'h1;
                end else if (scl_fall && q.bcnt == 4'h8) begin
                    d.bcnt = 4'h0;
                    d.sda_oe_b = 1'b0;
                    if (q.st == DFP_BUS_ADDR) begin
                        if (q.sh[7:1] == BUS_ADDR) begin
                            d.rw = q.sh[0];
                            d.st = DFP_BUS_ADDR_ACK;
                        end else begin
                            d.sda_oe_b = 1'b1;
                            d.st = DFP_BUS_IDLE;
                        end
                    end else if (q.st == DFP_BUS_CMD) begin
                        d.ptr = q.sh;
                        d.st = DFP_BUS_CMD_ACK;
                    end else begin
                        d.st = DFP_BUS_WDATA_ACK;
                        case (q.ptr)
                            `DFP_ADDR_MAIN_CONFIG: d.main_cfg = q.sh;
                            `DFP_ADDR_ALERT_ALLOW: d.allow = q.sh[1:0];
                            `DFP_ADDR_INVERT: d.invert = q.sh[1:0];
                            `DFP_ADDR_DRIVE_TYPE: d.push_pull = q.sh[1:0];
                            `DFP_ADDR_BASE_FREQ: d.base_sel = q.sh[3:0];
                            `DFP_ADDR_DRIVE1: drive_wr[0] = 1'b1;
                            `DFP_ADDR_DIVIDER1: d.divider[0] = q.sh;
                            `DFP_ADDR_CONTROL1: d.control[0] = q.sh;
                            `DFP_ADDR_DRIVE2: drive_wr[1] = 1'b1;
                            `DFP_ADDR_DIVIDER2: d.divider[1] = q.sh;
                            `DFP_ADDR_CONTROL2: d.control[1] = q.sh;
                            default: d.st = DFP_BUS_WDATA_ACK;
                        endcase
                    end
                end
            end
            DFP_BUS_ADDR_ACK, DFP_BUS_CMD_ACK, DFP_BUS_WDATA_ACK: begin
                if (scl_fall) begin
                    d.sda_oe_b = 1'b1;
                    d.bcnt = 4'h0;
                    if (q.st == DFP_BUS_ADDR_ACK && q.rw) begin
                        // first read bit goes out on this same fall
                        d.sda_oe_b = rd_data[7];
                        d.sh = {rd_data[6:0], 1'b0};
                        d.bcnt = 4'h1;
                        d.st = DFP_BUS_RDATA;
                    end else if (q.st == DFP_BUS_ADDR_ACK) begin
                        d.st = DFP_BUS_CMD;
                    end else begin
                        if (q.st == DFP_BUS_WDATA_ACK) begin
                            d.ptr = q.ptr + 8'h01;
                        end
                        d.st = DFP_BUS_WDATA;
                    end
                end
            end
            DFP_BUS_RDATA: begin
                if (scl_fall) begin
                    if (q.bcnt == 4'h8) begin
                        d.sda_oe_b = 1'b1;
                        d.st = DFP_BUS_RDATA_ACK;
                    end else begin
                        d.sda_oe_b = q.sh[7];
                        d.sh = {q.sh[6:0], 1'b0};
                        d.bcnt = q.bcnt + 4'h1;
                    end
                end
            end
            DFP_BUS_RDATA_ACK: begin
                if (scl_rise) begin
                    d.host_ack = !smb_data_i;
                end else if (scl_fall) begin
                    if (q.host_ack) begin
                        d.ptr = q.ptr + 8'h01;
                        d.st = DFP_BUS_ADDR_ACK;
                    end else begin
                        d.st = DFP_BUS_IDLE;
                    end
                end
            end
            default: begin
                d.st = DFP_BUS_IDLE;
                d.sda_oe_b = 1'b1;
            end
        endcase
        if (bus_start) begin
            d.st = DFP_BUS_ADDR;
            d.bcnt = 4'h0;
            d.sda_oe_b = 1'b1;
        end else if (bus_stop) begin
            d.st = DFP_BUS_IDLE;
            d.sda_oe_b = 1'b1;
        end

        for (int i = 0; i < 2; i++) begin
            // R13 R11 direct writes only outside closed loop
            if (!q.control[i][`DFP_CLOSED_LOOP_BIT]) begin
                if (drive_wr[i]) begin
                    d.drive[i] = q.sh;
                end
            end else if (tick[i]) begin
                // R14 R18 scaled target, host matches edges
                tgt_eff = 19'(tach_target_i[i]) <<
                    q.control[i][`DFP_SCALE_HI:`DFP_SCALE_LO];
                // R17 one step per interval
                if (19'(tach_count_i[i]) > tgt_eff) begin
                    sum = {1'b0, q.drive[i]} + {1'b0, fan_step_i};
                    d.drive[i] = sum[8] ? 8'hFF : sum[7:0];
                end else if (19'(tach_count_i[i]) < tgt_eff) begin
                    d.drive[i] = (q.drive[i] < fan_step_i) ? 8'h00 : q.drive[i] - fan_step_i;
                end
            end
        end

        // R01 R02 R19 alert gating
        d.alert_b = !((|(fan_error_i & q.allow)) && !q.main_cfg[`DFP_ALERT_BLOCK_BIT]);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // R20 reset defaults
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q.scl <= 1'b1;
            q.sda <= 1'b1;
            q.st <= DFP_BUS_IDLE;
            q.bcnt <= 4'h0;
            q.sh <= 8'h00;
            q.ptr <= 8'h00;
            q.rw <= 1'b0;
            q.host_ack <= 1'b0;
            q.sda_oe_b <= 1'b1;
            q.main_cfg <= `DFP_RST_MAIN_CONFIG;
            q.allow <= 2'h0;
            q.invert <= 2'h0;
            q.push_pull <= 2'h0;
            q.base_sel <= 4'h0;
            q.drive <= {`DFP_RST_ZERO, `DFP_RST_ZERO};
            q.divider <= {`DFP_RST_DIVIDER, `DFP_RST_DIVIDER};
            q.control <= {`DFP_RST_CONTROL, `DFP_RST_CONTROL};
            q.alert_b <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // open drain data line: only the enable moves
    assign smb_data_o = 1'b0;
    assign smb_data_oe_b_o = q.sda_oe_b;
    assign alert_b_o = q.alert_b;
    // R15 edges field handed to tach counters
    assign tach_edges_o[0] = q.control[0][`DFP_EDGES_HI:`DFP_EDGES_LO];
    assign tach_edges_o[1] = q.control[1][`DFP_EDGES_HI:`DFP_EDGES_LO];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_loop_tick(int i);
        q.control[i][`DFP_CLOSED_LOOP_BIT] && tick[i];
    endsequence

    sequence s_above(int i);
        19'(tach_count_i[i]) > (19'(tach_target_i[i]) << q.control[i][6:5]);
    endsequence

    sequence s_below(int i);
        19'(tach_count_i[i]) < (19'(tach_target_i[i]) << q.control[i][6:5]);
    endsequence

    alert_raise_a: assert property ( // R01
        (fan_error_i[0] && q.allow[0] && !q.main_cfg[7]) |=> !alert_b_o)
        else $error("allowed error did not assert alert");
    alert_raise2_a: assert property ( // R01
        (fan_error_i[1] && q.allow[1] && !q.main_cfg[7]) |=> !alert_b_o)
        else $error("allowed channel two error did not assert alert");
    alert_quiet_a: assert property ( // R02
        (q.allow == 2'b00) |=> alert_b_o)
        else $error("alert asserted with no channel allowed");
    alert_block_a: assert property ( // R19
        q.main_cfg[7] |=> alert_b_o)
        else $error("alert asserted while globally blocked");
    write_discard_a: assert property ( // R11
        (drive_wr[0] && q.control[0][7] && !tick[0]) |=> $stable(q.drive[0]))
        else $error("drive write taken in closed loop");
    direct_write_a: assert property ( // R13
        (drive_wr[1] && !q.control[1][7]) |=> q.drive[1] == $past(q.sh))
        else $error("direct drive write not applied");
    step_up_a: assert property ( // R17
        (s_loop_tick(0) ##0 s_above(0) ##0 q.drive[0] <= 8'hFF - fan_step_i)
        |=> q.drive[0] == $past(q.drive[0]) + $past(fan_step_i))
        else $error("closed loop step up wrong");
    step_sat_a: assert property ( // R17
        (s_loop_tick(0) ##0 s_above(0) ##0 q.drive[0] > 8'hFF - fan_step_i) |=> &q.drive[0])
        else $error("closed loop step up did not saturate");
    step_down_a: assert property ( // R17
        (s_loop_tick(0) ##0 s_below(0) ##0 q.drive[0] >= fan_step_i)
        |=> q.drive[0] == $past(q.drive[0]) - $past(fan_step_i))
        else $error("closed loop step down wrong");
    step_floor_a: assert property ( // R17
        (s_loop_tick(0) ##0 s_below(0) ##0 q.drive[0] < fan_step_i) |=> q.drive[0] == 8'h00)
        else $error("closed loop step down did not stop at zero");
    loop_hold_a: assert property ( // R13
        (s_loop_tick(0) ##0 19'(tach_count_i[0]) == (19'(tach_target_i[0]) << q.control[0][6:5]))
        |=> $stable(q.drive[0]))
        else $error("closed loop drive moved at target");
    hold_between_a: assert property ( // R17
        (q.control[0][7] && !tick[0]) |=> $stable(q.drive[0]))
        else $error("closed loop drive moved between ticks");
    readback_a: assert property ( // R10
        (q.ptr == `DFP_ADDR_DRIVE1) |-> rd_data == q.drive[0])
        else $error("drive readback differs from applied value");

endmodule // dfp_fan_drive

// ===== verification/dfp_fan_model.sv
// two fan model: pulled-up pwm wires, tach counts and error status
`timescale 1ns/1ps
module dfp_fan_model (
    input wire logic [1:0] pwm_i,
    input wire logic [1:0] pwm_oe_b_i,
    input wire logic fast_i,
    input wire logic [1:0] stall_i,
    output logic [1:0] wire_o,
    output logic [1:0][15:0] tach_o,
    output logic [1:0] error_o
);
    // released line floats up, so open drain reads high
    assign wire_o = pwm_oe_b_i | pwm_i;
    // smaller count means a faster fan
    assign tach_o[0] = fast_i ? 16'h0040 : 16'h0400;
    assign tach_o[1] = tach_o[0];
    assign error_o = stall_i;
endmodule // dfp_fan_model

// ===== verification/tb_top.sv
// fan drive testbench: register bus, alert, pwm duty and closed loop
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] DEV = 7'h10;
    logic clk_i, rst_b_i, scl, sda_h, smb_data_o, smb_data_oe_b_o, alert_b_o, fast;
    logic [1:0] stall, fan_error, pwm_o, pwm_oe_b_o, lvl;
    logic [7:0] fan_step, rd;
    logic [1:0][15:0] tach, target;
    logic [1:0][1:0] tach_edges_o;
    logic [7:0] ra [12] = '{8'h20, 8'h29, 8'h2A, 8'h2B, 8'h2D, 8'h30, 8'h31, 8'h32, 8'h40,
        8'h41, 8'h42, 8'h2C};
    logic [7:0] rv [12] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h2B, 8'h00,
        8'h01, 8'h2B, 8'h00};
    int fail_count, checked;
    wire sda_w = sda_h & (smb_data_oe_b_o | smb_data_o);

    dfp_fan_drive #(.BUS_ADDR(DEV), .UPDATE_UNIT_CYCLES(20)) i_dfp_fan_drive (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .smb_clk_i(scl), .smb_data_i(sda_w),
        .smb_data_o(smb_data_o), .smb_data_oe_b_o(smb_data_oe_b_o),
        .alert_b_o(alert_b_o), .fan_error_i(fan_error), .fan_step_i(fan_step),
        .tach_count_i(tach), .tach_target_i(target), .pwm_o(pwm_o),
        .pwm_oe_b_o(pwm_oe_b_o), .tach_edges_o(tach_edges_o));
    dfp_fan_model i_dfp_fan_model (.pwm_i(pwm_o), .pwm_oe_b_i(pwm_oe_b_o), .fast_i(fast),
        .stall_i(stall), .wire_o(lvl), .tach_o(tach), .error_o(fan_error));

    initial begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_h = b;
        w(4);
        scl = 1;
        w(4);
        r = sda_w;
        w(4);
        scl = 0;
        w(4);
    endtask
    // start when set, stop otherwise; data is set with clock low, then flips with clock high
    task automatic frame(input logic start);
        sda_h = start;
        w(4);
        scl = 1;
        w(4);
        sda_h = !start ? 1'b1 : 1'b0;
        w(4);
        if (start) scl = 0;
        w(4);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic wr, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
        xbit(1'b1, a);
        if (wr) chk(a, 1'b0);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        frame(1);
        xbyte({DEV, 1'b0}, 1, r);
        xbyte(a, 1, r);
        xbyte(d, 1, r);
        frame(0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        frame(1);
        xbyte({DEV, 1'b0}, 1, d);
        xbyte(a, 1, d);
        frame(1);
        xbyte({DEV, 1'b1}, 1, d);
        xbyte(8'hFF, 0, d);
        frame(0);
        chk(d, exp);
    endtask
    // one settling period, then high and released cycles over one period
    task automatic duty(input int ch, input int n, input int hi, input int oe);
        logic [15:0] h, o, e;
        logic p;
        h = '0;
        o = '0;
        e = '0;
        w(n);
        p = lvl[ch];
        repeat (n) begin
            @(negedge clk_i);
            h += lvl[ch];
            o += pwm_oe_b_o[ch];
            e += lvl[ch] & !p;
            p = lvl[ch];
        end
        chk(h, hi[15:0]);
        chk(o, oe[15:0]);
        chk(e, 16'h0001);
    endtask
    task automatic wrap_up();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        w(90000);
        fail_count++;
        wrap_up();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        {scl, sda_h, rst_b_i, fast, stall, fan_step} = {3'b110, 1'b0, 2'b00, 8'h30};
        target = {16'h0100, 16'h0100};
        w(8);
        rst_b_i = 1;
        w(2);
        reg_wr(8'h2C, 8'h5A);
        for (int i = 0; i < 12; i++) rd_chk(ra[i], rv[i]);
        stall = 2'b01;
        w(3);
        chk(alert_b_o, 1'b1);
        reg_wr(8'h29, 8'h01);
        w(2);
        chk(alert_b_o, 1'b0);
        reg_wr(8'h20, 8'hC0);
        w(2);
        chk(alert_b_o, 1'b1);
        reg_wr(8'h20, 8'h40);
        stall = 2'b10;
        w(2);
        chk(alert_b_o, 1'b1);
        reg_wr(8'h29, 8'h02);
        w(2);
        chk(alert_b_o, 1'b0);
        stall = 2'b00;
        for (int e = 0; e < 4; e++) begin
            reg_wr(8'h42, {3'b001, e[1:0], 3'b011});
            chk(tach_edges_o[1], e[1:0]);
            rd_chk(8'h42, {3'b001, e[1:0], 3'b011});
        end
        // ch1 open drain inverted at the second base, ch0 push-pull
        reg_wr(8'h2B, 8'h01);
        reg_wr(8'h2A, 8'h02);
        reg_wr(8'h2D, 8'h04);
        reg_wr(8'h30, 8'h80);
        reg_wr(8'h40, 8'hC0);
        fork
            duty(0, 7650, 3840, 0);
            duty(1, 10200, 2520, 2520);
        join
        reg_wr(8'h31, 8'h00);
        reg_wr(8'h30, 8'h40);
        reg_wr(8'h2D, 8'h00);
        reg_wr(8'h41, 8'h02);
        reg_wr(8'h40, 8'h80);
        fork
            duty(0, 7650, 1920, 0);
            duty(1, 15300, 7620, 7620);
        join
        reg_wr(8'h32, 8'h80);
        w(400);
        reg_wr(8'h32, 8'hC0);
        reg_wr(8'h30, 8'h12);
        rd_chk(8'h30, 8'hFF);
        reg_wr(8'h32, 8'hE0);
        w(400);
        rd_chk(8'h30, 8'h00);
        wrap_up();
    end
endmodule // tb_top
